/* File: inc/glue_pkg.sv */
// Constants for the single-board glue logic
package glue_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // Top 8K for device registers and the ROM window, RAM below 56K
    localparam logic [15:0] DEV_BASE = 16'he000;
    localparam logic [2:0] DEV_TOP_BITS = 3'h7;
    // Device register offsets inside the reserved region
    localparam logic [12:0] OFS_PORT_A_DATA = 13'h0000;
    localparam logic [12:0] OFS_PORT_B_DATA = 13'h0001;
    localparam logic [12:0] OFS_PORT_A_DIR = 13'h0002;
    localparam logic [12:0] OFS_PORT_B_DIR = 13'h0003;
    localparam logic [12:0] OFS_IRQ_STAT = 13'h0004;
    localparam logic [12:0] OFS_IRQ_MASK = 13'h0005;
    localparam logic [12:0] OFS_TICK_ACK = 13'h0006;
    // ROM window and the fixed start location
    localparam logic [15:0] ROM_BASE = 16'hfc00;
    localparam logic [15:0] START_ADDR = 16'hfc00;
    localparam int N_IRQ_LINES = 4;
    localparam int N_IO = 16;
    // Refresh tick period
    localparam int REFRESH_PERIOD_US = 1000;
    localparam int CLK_MHZ = 250;
    localparam int REFRESH_CYCLES = REFRESH_PERIOD_US * CLK_MHZ;
    localparam int POR_HOLD_US = 10000;
    localparam int POR_CYCLES = POR_HOLD_US * CLK_MHZ;
    // Strap codes for the interval
    localparam logic [2:0] RATE_1X = 3'h0;
    localparam logic [2:0] RATE_2X = 3'h1;
    localparam logic [2:0] RATE_4X = 3'h2;
    localparam logic [2:0] RATE_8X = 3'h3;
    localparam logic [2:0] RATE_16X = 3'h4;
    localparam logic [2:0] RATE_EXT = 3'h5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

/* File: hdl/glue_logic.sv */
// Address decode, refresh timer, power-on reset and I/O pool of the board
`timescale 1ns/1ns
// Function
// RL1: Devices stay idle unless their own address and control are both present.
// RL2: Each region decodes its own address; no central select lines exist. Here one decode drives ram_sel_out, rom_sel_out and dev_sel_out.
// RL3: Device registers are plain memory locations, any access reaches them.
// RL4: Top 8K holds device registers; memory is confined to lower 56K. Here the top 1K of it, from ROM_BASE up, selects the ROM.
// RL5: Bus has eight data lines, sixteen address lines and control lines.
// RL6: Board generates the memory refresh tick, also the interrupt timebase.
// RL7: Periodic interrupt raised at an interval derived from 1 ms refresh.
// RL8: Interval selectable as one, two, four, eight or sixteen refresh periods.
// RL9: Wire strap picks the rate; an external source may supply the interval.
// RL10: Processor held in reset after power-up until the supply settles.
// RL11: After reset, execution starts at a fixed location in the ROM.
// RL12: Sixteen programmable I/O lines and four interrupt request lines.
// RL13: Periodic interrupt stays asserted until software acknowledges by access.
// RL14: Reset hold is a parameterised cycle count after power good.
module glue_logic
    import glue_pkg::*;
#(
    parameter int REFRESH_CNT = glue_pkg::REFRESH_CYCLES,
    parameter int POR_CNT = glue_pkg::POR_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Power and straps
    input wire logic power_good_in,
    input wire logic [2:0] rate_strap_in,
    input wire logic ext_tick_in,
    // Processor bus
    input wire logic [glue_pkg::ADDR_W-1:0] bus_addr_in,
    input wire logic [glue_pkg::DATA_W-1:0] bus_data_in,
    output logic [glue_pkg::DATA_W-1:0] bus_data_out,
    output logic bus_data_oe_out,
    input wire logic bus_valid_in,
    input wire logic bus_rw_in,
    // Selects and reset toward the host processor
    output logic ram_sel_out,
    output logic rom_sel_out,
    output logic dev_sel_out,
    output logic host_processor_reset_out,
    output logic [glue_pkg::ADDR_W-1:0] start_addr_out,
    output logic refresh_tick_out,
    output logic host_processor_irq_out,
    // Programmable I/O
    input wire logic [glue_pkg::N_IO-1:0] io_in,
    output logic [glue_pkg::N_IO-1:0] io_out,
    output logic [glue_pkg::N_IO-1:0] io_oe_out,
    input wire logic [glue_pkg::N_IRQ_LINES-1:0] irq_line_in
);
    import glue_pkg::*;

    logic [31:0] ref_cnt_r, ref_cnt_nxt;
    logic [3:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic ext_d_r, ext_d_nxt;
    logic tick_irq_r, tick_irq_nxt;
    logic [31:0] por_cnt_r, por_cnt_nxt;
    logic por_hold_r, por_hold_nxt;
    logic [N_IO-1:0] io_data_r, io_data_nxt;
    logic [N_IO-1:0] io_dir_r, io_dir_nxt;
    logic [N_IRQ_LINES-1:0] irq_stat_r, irq_stat_nxt;
    logic [N_IRQ_LINES-1:0] irq_mask_r, irq_mask_nxt;
    logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
    logic rd_oe_r, rd_oe_nxt;
    logic in_dev, dev_acc, rd, wr, div_hit, sel_tick, ack;
    logic [12:0] ofs;

    // Decode from the common address; region chosen by its own bits
    assign in_dev = (bus_addr_in[15:13] == DEV_TOP_BITS); // [RL4] [RL2]
    assign ofs = bus_addr_in[12:0];
    assign dev_acc = bus_valid_in && in_dev && !por_hold_r; // [RL1]
    // ROM reads leave the data bus to the ROM board
    assign rd = dev_sel_out && bus_rw_in; // [RL3] [RL1]
    assign wr = dev_sel_out && !bus_rw_in; // [RL3]
    assign ram_sel_out = bus_valid_in && !in_dev && !por_hold_r; // [RL1] [RL4]
    assign rom_sel_out = dev_acc && (bus_addr_in >= ROM_BASE); // [RL11]
    assign dev_sel_out = dev_acc && (bus_addr_in < ROM_BASE);
    assign ack = dev_acc && (ofs == OFS_TICK_ACK); // [RL13]

    always_comb begin
        case (rate_strap_in) // [RL8] [RL9]
            RATE_1X: div_hit = 1'b1;
            RATE_2X: div_hit = (div_r[0] == 1'b1);
            RATE_4X: div_hit = (div_r[1:0] == 2'h3);
            RATE_8X: div_hit = (div_r[2:0] == 3'h7);
            RATE_16X: div_hit = (div_r == 4'hf);
            default: div_hit = 1'b0;
        endcase
    end

    always_comb begin
        ref_cnt_nxt = ref_cnt_r;
        div_nxt = div_r;
        tick_nxt = 1'b0;
        ext_d_nxt = ext_tick_in;
        sel_tick = 1'b0;
        // Free-running refresh tick each 1 ms
        if (ref_cnt_r == 32'(REFRESH_CNT - 1)) begin // [RL6] [RL7]
            ref_cnt_nxt = 32'h0;
            tick_nxt = 1'b1;
        end else begin
            ref_cnt_nxt = ref_cnt_r + 32'h1;
        end
        if (tick_r) begin
            div_nxt = div_r + 4'h1;
            sel_tick = div_hit;
        end
        if (rate_strap_in == RATE_EXT) begin // [RL9]
            sel_tick = ext_tick_in && !ext_d_r;
        end
        // Set beats acknowledge in the same cycle
        tick_irq_nxt = tick_irq_r;
        if (ack) begin
            tick_irq_nxt = 1'b0;
        end
        if (sel_tick) begin // [RL13]
            tick_irq_nxt = 1'b1;
        end
    end

    always_comb begin
        por_cnt_nxt = por_cnt_r;
        por_hold_nxt = por_hold_r;
        // Counting restarts whenever power dips
        if (!power_good_in) begin // [RL14]
            por_cnt_nxt = 32'h0;
            por_hold_nxt = 1'b1;
        end else if (por_cnt_r == 32'(POR_CNT - 1)) begin // [RL10]
            por_hold_nxt = 1'b0;
        end else begin
            por_cnt_nxt = por_cnt_r + 32'h1;
        end
    end

    always_comb begin
        io_data_nxt = io_data_r;
        io_dir_nxt = io_dir_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        rd_data_nxt = RESET_BYTE;
        rd_oe_nxt = 1'b0;
        if (wr) begin
            case (ofs)
                OFS_PORT_A_DATA: io_data_nxt[7:0] = bus_data_in;
                OFS_PORT_B_DATA: io_data_nxt[15:8] = bus_data_in;
                OFS_PORT_A_DIR: io_dir_nxt[7:0] = bus_data_in;
                OFS_PORT_B_DIR: io_dir_nxt[15:8] = bus_data_in;
                OFS_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~bus_data_in[3:0];
                OFS_IRQ_MASK: irq_mask_nxt = bus_data_in[3:0];
                default: irq_stat_nxt = irq_stat_r;
            endcase
        end
        irq_stat_nxt = irq_stat_nxt | irq_line_in; // [RL12]
        if (rd) begin // [RL3]
            rd_oe_nxt = 1'b1;
            case (ofs)
                OFS_PORT_A_DATA: rd_data_nxt = (io_in[7:0] & ~io_dir_r[7:0])
                    | (io_data_r[7:0] & io_dir_r[7:0]);
                OFS_PORT_B_DATA: rd_data_nxt = (io_in[15:8] & ~io_dir_r[15:8])
                    | (io_data_r[15:8] & io_dir_r[15:8]);
                OFS_PORT_A_DIR: rd_data_nxt = io_dir_r[7:0];
                OFS_PORT_B_DIR: rd_data_nxt = io_dir_r[15:8];
                OFS_IRQ_STAT: rd_data_nxt = {3'h0, tick_irq_r, irq_stat_r};
                OFS_IRQ_MASK: rd_data_nxt = {4'h0, irq_mask_r};
                default: rd_data_nxt = RESET_BYTE;
            endcase
        end
    end

    // Timer group: refresh count, rate divider and tick interrupt
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ref_cnt_r <= 32'h0;
            div_r <= 4'h0;
            tick_r <= 1'b0;
            ext_d_r <= 1'b0;
            tick_irq_r <= 1'b0;
        end else if (clk_en_in) begin
            ref_cnt_r <= ref_cnt_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            ext_d_r <= ext_d_nxt;
            tick_irq_r <= tick_irq_nxt;
        end
    end

    // Power-on hold group
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            por_cnt_r <= 32'h0;
            por_hold_r <= 1'b1;
        end else if (clk_en_in) begin
            por_cnt_r <= por_cnt_nxt;
            por_hold_r <= por_hold_nxt;
        end
    end

    // Device registers and read data group
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            io_data_r <= 16'h0000;
            io_dir_r <= 16'h0000;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
            rd_data_r <= RESET_BYTE;
            rd_oe_r <= 1'b0;
        end else if (clk_en_in) begin
            io_data_r <= io_data_nxt;
            io_dir_r <= io_dir_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            rd_data_r <= rd_data_nxt;
            rd_oe_r <= rd_oe_nxt;
        end
    end

    assign bus_data_out = rd_data_r; // [RL5]
    assign bus_data_oe_out = rd_oe_r;
    assign host_processor_reset_out = por_hold_r; // [RL10]
    assign start_addr_out = START_ADDR; // [RL11]
    assign refresh_tick_out = tick_r; // [RL6]
    assign host_processor_irq_out = tick_irq_r || |(irq_stat_r & irq_mask_r); // [RL7] [RL12]
    assign io_out = io_data_r; // [RL12]
    assign io_oe_out = io_dir_r;
endmodule // glue_logic

/* File: test/glue_chk.sv */
// Port-level assertions for the glue logic
`timescale 1ns/1ns
module glue_chk
    import glue_pkg::*;
#(
    parameter int REFRESH_CNT = 20,
    parameter int POR_CNT = 10
) (
    // Watched ports
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic bus_valid_in,
    input wire logic bus_rw_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic [2:0] rate_strap_in,
    input wire logic ram_sel_out,
    input wire logic rom_sel_out,
    input wire logic dev_sel_out,
    input wire logic host_processor_reset_out,
    input wire logic refresh_tick_out,
    input wire logic host_processor_irq_out,
    input wire logic bus_data_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    wire any_sel = ram_sel_out | rom_sel_out | dev_sel_out;
    wire go = bus_valid_in && !host_processor_reset_out;
    wire in_dev = bus_addr_in >= DEV_BASE && bus_addr_in < ROM_BASE;
    property p_ram; go && bus_addr_in < DEV_BASE |-> ram_sel_out && !dev_sel_out; endproperty
    a_ram: assert property (p_ram) else $error("ram select wrong");
    property p_dev; go && in_dev |-> dev_sel_out && !ram_sel_out && !rom_sel_out; endproperty
    a_dev: assert property (p_dev) else $error("device select wrong");
    property p_rom; go && bus_addr_in >= ROM_BASE |-> rom_sel_out && !dev_sel_out; endproperty
    a_rom: assert property (p_rom) else $error("rom select wrong");
    property p_idle; !bus_valid_in |-> !any_sel; endproperty
    a_idle: assert property (p_idle) else $error("select without access");
    property p_hold; host_processor_reset_out |-> !any_sel; endproperty
    a_hold: assert property (p_hold) else $error("select during hold");
    property p_por; $fell(rst_in) |-> host_processor_reset_out [*8]; endproperty
    a_por: assert property (p_por) else $error("reset hold too short");
    property p_irq;
        refresh_tick_out && rate_strap_in == RATE_1X && !host_processor_reset_out
            |=> host_processor_irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("tick gave no interrupt");
    property p_rd; go && bus_rw_in && in_dev |=> bus_data_oe_out; endproperty
    a_rd: assert property (p_rd) else $error("device read not driven");
    property p_rom_quiet;
        go && bus_rw_in && bus_addr_in >= ROM_BASE |=> !bus_data_oe_out;
    endproperty
    a_rom_quiet: assert property (p_rom_quiet) else $error("rom read drove data");
    property p_tick; refresh_tick_out |=> !refresh_tick_out [*8]; endproperty
    a_tick: assert property (p_tick) else $error("refresh tick too close");
    c_tick: cover property (refresh_tick_out);
    c_rd: cover property (go && bus_rw_in && in_dev);
    c_irq: cover property (host_processor_irq_out);
endmodule // glue_chk

/* File: test/periph_model.sv */
// Peripheral board model on the I/O and interrupt pins
`timescale 1ns/1ns
module periph_model #(
    parameter logic [15:0] PAT = 16'h5a3c
) (
    // From the glue logic and the bench
    input wire logic [15:0] io_drv_in,
    input wire logic [15:0] io_en_in,
    input wire logic [3:0] req_in,
    // Toward the glue logic
    output logic [15:0] io_pin_out,
    output logic [3:0] irq_line_out
);
    // Driven lines loop back; released ones show the board's own pattern
    assign io_pin_out = (io_drv_in & io_en_in) | (PAT & ~io_en_in);
    assign irq_line_out = req_in;
endmodule // periph_model

/* File: test/testbench.sv */
// Self-checking bench for the glue logic
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %0t mismatch", $time); end end
module testbench;
    import glue_pkg::*;
    logic core_clk_in = 0, rst_in = 1, pg = 0, ext = 0, valid = 0, rw = 0;
    logic [2:0] strap = 3'h6;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, rd;
    logic [3:0] req = 4'h0;
    wire [15:0] io_in, io_out, io_oe, start;
    wire [3:0] irq_line;
    wire [7:0] dout;
    wire ram, rom, dev, hrst, tick, irq, oe;
    int errors = 0, n_tests = 0, cyc = 0;
    always #2 core_clk_in = ~core_clk_in;
    glue_logic #(.REFRESH_CNT(20), .POR_CNT(10)) uut (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .clk_en_in(1'b1), .power_good_in(pg), .rate_strap_in(strap),
        .ext_tick_in(ext), .bus_addr_in(addr), .bus_data_in(wd), .bus_data_out(dout),
        .bus_data_oe_out(oe), .bus_valid_in(valid), .bus_rw_in(rw), .ram_sel_out(ram),
        .rom_sel_out(rom), .dev_sel_out(dev), .host_processor_reset_out(hrst),
        .start_addr_out(start), .refresh_tick_out(tick), .host_processor_irq_out(irq),
        .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe), .irq_line_in(irq_line));
    periph_model pm (.io_drv_in(io_out), .io_en_in(io_oe), .req_in(req),
        .io_pin_out(io_in), .irq_line_out(irq_line));
    task automatic acc(input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_in) begin valid <= 1; rw <= r; addr <= a; wd <= d; end
        @(posedge core_clk_in) valid <= 0;
        #1 rd = dout;
    endtask
    task automatic wait_irq(output int t);
        t = 0;
        repeat (1000) if (irq !== 1'b1) begin @(posedge core_clk_in); #1; t += tick; end
    endtask
    task automatic t_por;
        int n = 0;
        repeat (3) @(posedge core_clk_in);
        rst_in <= 0;
        repeat (5) @(posedge core_clk_in);
        pg <= 1;
        #1 `CHK(hrst, 1'b1)
        while (hrst === 1'b1 && n < 100) begin @(posedge core_clk_in); #1; n++; end
        `CHK(n >= 10 && n <= 12, 1'b1)
        `CHK(start, START_ADDR)
        $display("por done");
    endtask
    task automatic t_dec;
        logic [15:0] at [6] = '{16'h0000, 16'hdfff, 16'he000, 16'hfbff, 16'hfc00, 16'hffff};
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk_in) begin valid <= 1; rw <= 1; addr <= at[i]; end
            #1 `CHK({ram, dev, rom}, (i < 2) ? 3'h4 : (i < 4) ? 3'h2 : 3'h1)
            `CHK(oe, i == 3 || i == 4)
        end
        @(posedge core_clk_in) valid <= 0;
        #1 `CHK(oe, 1'b0)
        $display("decode done");
    endtask
    task automatic t_io;
        acc(0, DEV_BASE + OFS_TICK_ACK, 8'h00);
        acc(0, DEV_BASE + OFS_PORT_A_DIR, 8'hff);
        acc(0, DEV_BASE + OFS_PORT_A_DATA, 8'ha5);
        `CHK(io_oe, 16'h00ff)
        `CHK(io_out[7:0], 8'ha5)
        acc(1, DEV_BASE + OFS_PORT_B_DATA, 8'h00);
        `CHK(oe, 1'b1)
        `CHK(rd, 8'h5a)
        acc(1, DEV_BASE + 16'h0100, 8'h00);
        `CHK(rd, 8'h00)
        @(posedge core_clk_in) req <= 4'h2;
        acc(0, DEV_BASE + OFS_IRQ_MASK, 8'h02);
        `CHK(irq, 1'b1)
        @(posedge core_clk_in) req <= 4'h0;
        acc(0, DEV_BASE + OFS_IRQ_STAT, 8'h02);
        `CHK(irq, 1'b0)
        $display("io done");
    endtask
    task automatic t_rate;
        int t;
        for (int s = 0; s < 5; s++) begin
            @(posedge core_clk_in) strap <= s[2:0];
            // Align to a firing of the new rate before counting
            acc(0, DEV_BASE + OFS_TICK_ACK, 8'h00);
            wait_irq(t);
            acc(0, DEV_BASE + OFS_TICK_ACK, 8'h00);
            `CHK(irq, 1'b0)
            wait_irq(t);
            `CHK(t, 1 << s)
        end
        @(posedge core_clk_in) strap <= RATE_EXT;
        acc(0, DEV_BASE + OFS_TICK_ACK, 8'h00);
        repeat (50) @(posedge core_clk_in);
        ext <= 1;
        #1 `CHK(irq, 1'b0)
        repeat (3) @(posedge core_clk_in);
        #1 `CHK(irq, 1'b1)
        $display("rate done");
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Ceiling well above the slowest interval sweep
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 8000) begin errors++; give_verdict; end
    end
    initial begin
        t_por;
        t_dec;
        t_io;
        t_rate;
        give_verdict;
    end
endmodule // testbench
bind glue_logic glue_chk #(.REFRESH_CNT(REFRESH_CNT), .POR_CNT(POR_CNT)) chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_valid_in(bus_valid_in),
    .bus_rw_in(bus_rw_in), .bus_addr_in(bus_addr_in), .rate_strap_in(rate_strap_in),
    .ram_sel_out(ram_sel_out), .rom_sel_out(rom_sel_out), .dev_sel_out(dev_sel_out),
    .host_processor_reset_out(host_processor_reset_out),
    .refresh_tick_out(refresh_tick_out), .host_processor_irq_out(host_processor_irq_out),
    .bus_data_oe_out(bus_data_oe_out));
